/* hw/ttsr_pkg.sv */
// Package of offsets, field layouts and constants for the triangle texture setup registers.
package ttsr_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the register port).
    // ------------------------------------------------------------------
    localparam logic [15:0] OFF_TEXEL_ROW_BASE = 16'hB504;
    localparam logic [15:0] OFF_TEXEL_COLUMN_BASE = 16'hB508;
    localparam logic [15:0] OFF_DEPTH_W_STEP_X = 16'hB50C;
    localparam logic [15:0] OFF_DEPTH_W_STEP_Y = 16'hB510;
    localparam logic [15:0] OFF_DEPTH_W_INITIAL = 16'hB514;
    localparam logic [15:0] OFF_MIP_LEVEL_STEP_X = 16'hB518;
    localparam logic [15:0] OFF_TEXEL_ROW_STEP_X = 16'hB51C;
    localparam logic [15:0] OFF_TEXEL_COLUMN_STEP_X = 16'hB520;
    localparam logic [15:0] OFF_MIP_LEVEL_STEP_Y = 16'hB524;
    localparam logic [15:0] OFF_TEXEL_ROW_STEP_Y = 16'hB528;
    localparam logic [15:0] OFF_TEXEL_COLUMN_STEP_Y = 16'hB52C;
    // Control register holding wrap enable and operation code.
    localparam logic [15:0] OFF_RENDER_CONTROL = 16'hB5F0;

    // ------------------------------------------------------------------
    // Field layouts.
    // ------------------------------------------------------------------
    localparam int BASE_WIDTH = 20;
    localparam int WRAP_ENABLE_BIT = 26;
    localparam int OPCODE_LSB = 27;
    localparam int OPCODE_WIDTH = 4;
    localparam int MIP_WRAP_LSB = 27;
    localparam int MIP_INT_LSB = 19;
    localparam logic [3:0] OP_PERSPECTIVE_A = 4'h5;
    localparam logic [3:0] OP_PERSPECTIVE_B = 4'h6;

    // Values after a load and for unmapped reads (contents are undefined; zero is used here).
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Register index type for the eleven parameter words.
    typedef enum logic [3:0]
    {
        TTSR_ROW_BASE = 4'b0000,
        TTSR_COL_BASE = 4'b0001,
        TTSR_W_STEP_X = 4'b0010,
        TTSR_W_STEP_Y = 4'b0011,
        TTSR_W_INIT = 4'b0100,
        TTSR_D_STEP_X = 4'b0101,
        TTSR_V_STEP_X = 4'b0110,
        TTSR_U_STEP_X = 4'b0111,
        TTSR_D_STEP_Y = 4'b1000,
        TTSR_V_STEP_Y = 4'b1001,
        TTSR_U_STEP_Y = 4'b1010
    } ttsr_index_t;

endpackage : ttsr_pkg

/* hw/ttsr_step_if.sv */
// Interface carrying the texture step operands between the setup bank and its stepper.
`timescale 1ns/10ps
interface ttsr_step_if;
    logic perspective;        // Perspective mode selected.
    logic wrap_enable;        // Texture edge wrap allowed.
    logic step_x;             // Advance one step in X.
    logic step_y;             // Advance one step in Y.
    logic load;               // Reload accumulators from start values.
    logic [31:0] w_init;      // W start value.
    logic [31:0] w_dx;        // W step per X.
    logic [31:0] w_dy;        // W step per Y.
    logic [31:0] d_dx;        // D step per X.
    logic [31:0] d_dy;        // D step per Y.
    logic [31:0] u_dx;        // U step per X.
    logic [31:0] u_dy;        // U step per Y.
    logic [31:0] v_dx;        // V step per X.
    logic [31:0] v_dy;        // V step per Y.
    logic [19:0] u_base;      // U common offset.
    logic [19:0] v_base;      // V common offset.
    logic [31:0] w_acc;       // Accumulated W.
    logic [7:0] mip_level;    // Selected mipmap level.
    logic [3:0] wrap_limit;   // Allowed edge wraps.
    logic [31:0] u_coord;     // U with base applied.
    logic [31:0] v_coord;     // V with base applied.

    modport bank
    (
        output perspective, wrap_enable, step_x, step_y, load, w_init, w_dx, w_dy,
        output d_dx, d_dy, u_dx, u_dy, v_dx, v_dy, u_base, v_base,
        input w_acc, mip_level, wrap_limit, u_coord, v_coord
    );
    modport stepper
    (
        input perspective, wrap_enable, step_x, step_y, load, w_init, w_dx, w_dy,
        input d_dx, d_dy, u_dx, u_dy, v_dx, v_dy, u_base, v_base,
        output w_acc, mip_level, wrap_limit, u_coord, v_coord
    );
endinterface : ttsr_step_if

/* hw/ttsr_stepper.sv */
// Texture attribute stepper that accumulates W, D, U and V from the setup values.
`timescale 1ns/10ps
module ttsr_stepper
(
    input wire logic clk,
    input wire logic rst,
    ttsr_step_if.stepper sif
);
    import ttsr_pkg::*;

    // All state of the stepper in one word.
    typedef struct packed
    {
        logic [31:0] w;
        logic [31:0] d;
        logic [31:0] u;
        logic [31:0] v;
    } ttsr_acc_t;

    ttsr_acc_t st;       // Registered state.
    ttsr_acc_t next_st;  // Next state.

    // ------------------------------------------------------------------
    // Pass a U or V delta on according to the coordinate mode.
    // ------------------------------------------------------------------
    // Both formats (S24.7 and S12.8.11) are added raw; only the point moves.
    function automatic logic [31:0] ttsr_uv_norm(input logic [31:0] val, input logic persp);
        if (persp)
        begin
            ttsr_uv_norm = val;
        end
        else
        begin
            ttsr_uv_norm = val;
        end
    endfunction : ttsr_uv_norm

    // ------------------------------------------------------------------
    // Accumulation.
    // ------------------------------------------------------------------
    // Load takes priority over stepping so a new triangle starts clean.
    always_comb
    begin
        next_st = st;
        if (sif.load)
        begin
            next_st.w = sif.w_init;
            next_st.d = RESET_WORD;
            next_st.u = RESET_WORD;
            next_st.v = RESET_WORD;
        end
        else if (sif.step_x)
        begin
            next_st.w = st.w + sif.w_dx;
            next_st.d = st.d + sif.d_dx;
            next_st.u = st.u + ttsr_uv_norm(sif.u_dx, sif.perspective);
            next_st.v = st.v + ttsr_uv_norm(sif.v_dx, sif.perspective);
        end
        else if (sif.step_y)
        begin
            next_st.w = st.w + sif.w_dy;
            next_st.d = st.d + sif.d_dy;
            next_st.u = st.u + ttsr_uv_norm(sif.u_dy, sif.perspective);
            next_st.v = st.v + ttsr_uv_norm(sif.v_dy, sif.perspective);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs: the integer field of D picks the mip level, base offsets added.
    assign sif.w_acc = st.w;
    assign sif.mip_level = st.d[MIP_INT_LSB +: 8];
    // Wrap count is shown only when wrapping is enabled; D keeps accumulating its wrap bits either way.
    assign sif.wrap_limit = sif.wrap_enable ? st.d[MIP_WRAP_LSB +: 4] : 4'h0;
    // Base offsets are 12.8 and applied as the common offset of each coordinate.
    assign sif.u_coord = st.u + {12'h000, sif.u_base};
    assign sif.v_coord = st.v + {12'h000, sif.v_base};

endmodule : ttsr_stepper

/* hw/ttsr_regs.sv */
// Triangle texture setup register bank with its attribute stepper.
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module ttsr_regs
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [15:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic STEP_X,
    input wire logic STEP_Y,
    input wire logic LOAD,
    output logic [31:0] W_ACC,
    output logic [7:0] MIP_LEVEL,
    output logic [3:0] WRAP_LIMIT,
    output logic [31:0] U_COORD,
    output logic [31:0] V_COORD,
    output logic PERSPECTIVE
);
    import ttsr_pkg::*;

    // ------------------------------------------------------------------
    // Register map and number formats.
    // ------------------------------------------------------------------
    // B504 row base: unsigned 12.8 in bits 19:0, bits 31:20 read as zero.
    // B508 column base: unsigned 12.8 in bits 19:0, bits 31:20 read as zero.
    // B50C depth step per X: signed, 12 integer and 19 fraction bits.
    // B510 depth step per Y: same signed layout as the X step.
    // B514 depth start: same layout; software keeps the sign clear.
    // B518 mip step per X: sign, four wrap bits, 8 integer, 19 fraction.
    // B51C row coordinate step per X.
    // B520 column coordinate step per X.
    // B524 mip step per Y: same layout as the X step.
    // B528 row coordinate step per Y.
    // B52C column coordinate step per Y.
    // B5F0 control: bit 26 allows edge wrap, bits 30:27 hold the operation.
    // The coordinate steps are signed 24.7 under the two perspective codes
    // and signed 12.8.11 (integer, filter, fraction) under all others.
    // Any other offset ignores a write and reads back as zero, so a stray
    // access from software can never disturb a triangle already set up.

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    // All bank state as one struct so reset and update stay in one place.
    // The output copies in the tail of the struct exist only to give every
    // pin its own flop; they repeat the stepper's results and the mode flag one cycle late.
    typedef struct packed
    {
        logic [31:0] row_base;
        logic [31:0] col_base;
        logic [31:0] w_sx;
        logic [31:0] w_sy;
        logic [31:0] w_init;
        logic [31:0] d_sx;
        logic [31:0] v_sx;
        logic [31:0] u_sx;
        logic [31:0] d_sy;
        logic [31:0] v_sy;
        logic [31:0] u_sy;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic [31:0] w_out;
        logic [7:0] mip_out;
        logic [3:0] wrap_out;
        logic [31:0] u_out;
        logic [31:0] v_out;
        logic persp_out;
    } ttsr_state_t;

    ttsr_state_t st;       // Registered state.
    ttsr_state_t next_st;  // Next state.
    ttsr_step_if sif();    // Link to the stepper.

    // ------------------------------------------------------------------
    // Mode decode, used by both the stepper link and the output flop.
    // ------------------------------------------------------------------
    // Only codes 0101 and 0110 select perspective; every other code, the
    // unused ones included, falls back to the plain coordinate format.
    function automatic logic ttsr_is_persp(input logic [31:0] ctrl);
        logic [3:0] op;
        op = ctrl[OPCODE_LSB +: OPCODE_WIDTH];
        ttsr_is_persp = (op == OP_PERSPECTIVE_A) || (op == OP_PERSPECTIVE_B);
    endfunction : ttsr_is_persp

    // Drive the stepper from the stored values.
    // The step words go across untouched: the two coordinate formats differ
    // only in where software places the binary point, so one adder serves
    // both modes and no shifter sits in the accumulation path.
    // The trade-off is that the stepper output is in whatever format the
    // current operation implies; the consumer must know the mode, which is
    // why the perspective flag is also brought out to a pin.
    // Strobes from the rasteriser share this clock and need no synchroniser.
    assign sif.perspective = ttsr_is_persp(st.ctrl);
    assign sif.wrap_enable = st.ctrl[WRAP_ENABLE_BIT];
    assign sif.step_x = STEP_X;
    assign sif.step_y = STEP_Y;
    assign sif.load = LOAD;
    assign sif.w_init = st.w_init;
    assign sif.w_dx = st.w_sx;
    assign sif.w_dy = st.w_sy;
    assign sif.d_dx = st.d_sx;
    assign sif.d_dy = st.d_sy;
    assign sif.u_dx = st.u_sx;
    assign sif.u_dy = st.u_sy;
    assign sif.v_dx = st.v_sx;
    assign sif.v_dy = st.v_sy;
    assign sif.u_base = st.col_base[BASE_WIDTH-1:0];
    assign sif.v_base = st.row_base[BASE_WIDTH-1:0];

    // The stepper shares clock and reset with the bank; its results are
    // captured below rather than driven straight to the pins.
    ttsr_stepper u_stepper
    (
        .clk(MCLK),
        .rst(RESET),
        .sif(sif.stepper)
    );

    // ------------------------------------------------------------------
    // Register writes, reads and output capture.
    // ------------------------------------------------------------------
    // Base registers keep only 20 bits; their reserved bits read as zero.
    always_comb
    begin
        next_st = st;
        // A write replaces the whole word at once; there are no byte
        // enables, so software always rewrites a full register.
        // Step and start words are stored exactly as written, sign included.
        if (WR)
        begin
            if (ADDR == OFF_TEXEL_ROW_BASE)
            begin
                next_st.row_base = {12'h000, WDATA[BASE_WIDTH-1:0]};
            end
            else if (ADDR == OFF_TEXEL_COLUMN_BASE)
            begin
                next_st.col_base = {12'h000, WDATA[BASE_WIDTH-1:0]};
            end
            else if (ADDR == OFF_DEPTH_W_STEP_X)
            begin
                next_st.w_sx = WDATA;
            end
            else if (ADDR == OFF_DEPTH_W_STEP_Y)
            begin
                next_st.w_sy = WDATA;
            end
            else if (ADDR == OFF_DEPTH_W_INITIAL)
            begin
                // Sign is stored as written; software keeps it clear.
                next_st.w_init = WDATA;
            end
            else if (ADDR == OFF_MIP_LEVEL_STEP_X)
            begin
                next_st.d_sx = WDATA;
            end
            else if (ADDR == OFF_TEXEL_ROW_STEP_X)
            begin
                next_st.v_sx = WDATA;
            end
            else if (ADDR == OFF_TEXEL_COLUMN_STEP_X)
            begin
                next_st.u_sx = WDATA;
            end
            else if (ADDR == OFF_MIP_LEVEL_STEP_Y)
            begin
                next_st.d_sy = WDATA;
            end
            else if (ADDR == OFF_TEXEL_ROW_STEP_Y)
            begin
                next_st.v_sy = WDATA;
            end
            else if (ADDR == OFF_TEXEL_COLUMN_STEP_Y)
            begin
                next_st.u_sy = WDATA;
            end
            else if (ADDR == OFF_RENDER_CONTROL)
            begin
                next_st.ctrl = WDATA;
            end
        end
        // The decode chains match the full sixteen-bit offset, so aliases
        // of a word at other addresses do not exist.
        // A write and a read of the same word in one cycle is not expected
        // from the master; should it occur, the read returns the old value.
        // Read data stand for exactly the cycle after the strobe.
        next_st.rdata = UNMAPPED_READ;
        // Reads have no side effects, so polling a word is harmless.
        if (RD)
        begin
            if (ADDR == OFF_TEXEL_ROW_BASE)
            begin
                next_st.rdata = st.row_base;
            end
            else if (ADDR == OFF_TEXEL_COLUMN_BASE)
            begin
                next_st.rdata = st.col_base;
            end
            else if (ADDR == OFF_DEPTH_W_STEP_X)
            begin
                next_st.rdata = st.w_sx;
            end
            else if (ADDR == OFF_DEPTH_W_STEP_Y)
            begin
                next_st.rdata = st.w_sy;
            end
            else if (ADDR == OFF_DEPTH_W_INITIAL)
            begin
                next_st.rdata = st.w_init;
            end
            else if (ADDR == OFF_MIP_LEVEL_STEP_X)
            begin
                next_st.rdata = st.d_sx;
            end
            else if (ADDR == OFF_TEXEL_ROW_STEP_X)
            begin
                next_st.rdata = st.v_sx;
            end
            else if (ADDR == OFF_TEXEL_COLUMN_STEP_X)
            begin
                next_st.rdata = st.u_sx;
            end
            else if (ADDR == OFF_MIP_LEVEL_STEP_Y)
            begin
                next_st.rdata = st.d_sy;
            end
            else if (ADDR == OFF_TEXEL_ROW_STEP_Y)
            begin
                next_st.rdata = st.v_sy;
            end
            else if (ADDR == OFF_TEXEL_COLUMN_STEP_Y)
            begin
                next_st.rdata = st.u_sy;
            end
            else if (ADDR == OFF_RENDER_CONTROL)
            begin
                next_st.rdata = st.ctrl;
            end
        end
        // Results are re-registered so every top output leaves a flop;
        // this costs one cycle of latency against the stepper.
        next_st.w_out = sif.w_acc;
        next_st.mip_out = sif.mip_level;
        next_st.wrap_out = sif.wrap_limit;
        next_st.u_out = sif.u_coord;
        next_st.v_out = sif.v_coord;
        next_st.persp_out = sif.perspective;
    end

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    // Edge N takes a write; edge N+1 can already read it back.
    // Edge N takes a read; RDATA holds the word from N to N+1, then zero.
    // Edge N takes a load or step; the stepper holds the result after N,
    // and the output flops show it after N+1.
    // The load wins over both steps, and an X step over a Y step, so the
    // walker may assert several strobes at once without corrupting a sum.
    // Sums wrap at 32 bits; software must size its steps so that no
    // accumulator crosses its sign over the span of one triangle.
    // Contents are undefined at power-on; zero keeps simulation clean.
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each a field of the registered state.
    // ------------------------------------------------------------------
    // Nothing combinational sits between a flop and a pin, so the paths
    // from this block to its neighbours are short and easy to close.
    assign RDATA = st.rdata;
    assign W_ACC = st.w_out;
    assign MIP_LEVEL = st.mip_out;
    assign WRAP_LIMIT = st.wrap_out;
    assign U_COORD = st.u_out;
    assign V_COORD = st.v_out;
    assign PERSPECTIVE = st.persp_out;

endmodule : ttsr_regs

/* sim/ttsr_regs_checker.sv */
// Checker of bus and stepper relations at the texture setup register bank ports.
`timescale 1ns/10ps
module ttsr_regs_checker
    import ttsr_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [15:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic STEP_X,
    input wire logic STEP_Y,
    input wire logic LOAD,
    input wire logic [31:0] W_ACC,
    input wire logic [7:0] MIP_LEVEL,
    input wire logic [3:0] WRAP_LIMIT,
    input wire logic [31:0] U_COORD,
    input wire logic [31:0] V_COORD,
    input wire logic PERSPECTIVE
);
    // ------------------------------------------------------------------
    // Shadows of the words the relations depend on.
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q; // Control word as last written.
    logic [31:0] w_start; // W start as last written.
    logic [31:0] w_dx; // W step per X as last written.
    logic [31:0] w_dy; // W step per Y as last written.
    logic persp_q; // Perspective expected from the control shadow.

    assign persp_q = (ctrl_q[30:27] == OP_PERSPECTIVE_A) || (ctrl_q[30:27] == OP_PERSPECTIVE_B);

    // Shadows follow the write strobe at the same edge as the bank itself.
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            ctrl_q <= 32'h0;
            w_start <= 32'h0;
            w_dx <= 32'h0;
            w_dy <= 32'h0;
        end
        else if (WR)
        begin
            case (ADDR)
                OFF_RENDER_CONTROL: ctrl_q <= WDATA;
                OFF_DEPTH_W_INITIAL: w_start <= WDATA;
                OFF_DEPTH_W_STEP_X: w_dx <= WDATA;
                OFF_DEPTH_W_STEP_Y: w_dy <= WDATA;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    // A write immediately followed by a read of the same word.
    sequence s_wr_rd;
        WR && ADDR == OFF_DEPTH_W_STEP_X ##1 RD && ADDR == OFF_DEPTH_W_STEP_X;
    endsequence

    AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data seen outside its cycle");
    AST_BASE_RESERVED: assert property (RD && ADDR == OFF_TEXEL_ROW_BASE
        |=> RDATA[31:20] == 12'h0)
        else $error("reserved base bits read nonzero");
    AST_READBACK: assert property (s_wr_rd |=> RDATA == $past(WDATA, 2))
        else $error("back to back read lost the write");
    AST_PERSPECTIVE: assert property ($stable(ctrl_q) |-> PERSPECTIVE == persp_q)
        else $error("perspective flag disagrees with code");
    AST_WRAP_OFF: assert property ($stable(ctrl_q) && !ctrl_q[26]
        |-> WRAP_LIMIT == 4'h0)
        else $error("wrap limit shown while wrap disabled");
    AST_LOAD_W: assert property (LOAD |=> ##1 W_ACC == w_start)
        else $error("load did not restore W start");
    AST_STEP_X_W: assert property (STEP_X && !LOAD |=> ##1 W_ACC == $past(W_ACC) + w_dx)
        else $error("X step added wrong W increment");
    AST_STEP_Y_W: assert property (STEP_Y && !STEP_X && !LOAD
        |=> ##1 W_ACC == $past(W_ACC) + w_dy)
        else $error("Y step added wrong W increment");
endmodule : ttsr_regs_checker

bind ttsr_regs ttsr_regs_checker u_chk (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .STEP_X(STEP_X), .STEP_Y(STEP_Y), .LOAD(LOAD),
    .W_ACC(W_ACC), .MIP_LEVEL(MIP_LEVEL), .WRAP_LIMIT(WRAP_LIMIT), .U_COORD(U_COORD),
    .V_COORD(V_COORD), .PERSPECTIVE(PERSPECTIVE));

/* sim/test_ttsr_regs.sv */
// Self-checking bench for the triangle texture setup register bank.
`timescale 1ns/10ps
module test_ttsr_regs;
    import ttsr_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observed signals.
    // ------------------------------------------------------------------
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic [15:0] ADDR = 16'h0;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic STEP_X = 1'b0;
    logic STEP_Y = 1'b0;
    logic LOAD = 1'b0;
    logic [31:0] RDATA, W_ACC, U_COORD, V_COORD;
    logic [7:0] MIP_LEVEL;
    logic [3:0] WRAP_LIMIT;
    logic PERSPECTIVE;
    int n_mismatch = 0;
    int compares = 0;
    // Offsets in register table order.
    localparam logic [15:0] OFFS [0:10] = '{OFF_TEXEL_ROW_BASE, OFF_TEXEL_COLUMN_BASE,
        OFF_DEPTH_W_STEP_X, OFF_DEPTH_W_STEP_Y, OFF_DEPTH_W_INITIAL, OFF_MIP_LEVEL_STEP_X,
        OFF_TEXEL_ROW_STEP_X, OFF_TEXEL_COLUMN_STEP_X, OFF_MIP_LEVEL_STEP_Y,
        OFF_TEXEL_ROW_STEP_Y, OFF_TEXEL_COLUMN_STEP_Y};
    // Step operands; one W step is negative to exercise signed wrap of the sum.
    localparam logic [31:0] VALS [0:10] = '{32'h0001_2345, 32'h000F_0F0F, 32'hFFFF_F000,
        32'h0000_0800, 32'h0123_4000, 32'h1A3C_0000, 32'h0000_1000, 32'h0000_2000,
        32'h0008_0000, 32'hFFFF_8000, 32'h0004_0000};

    ttsr_regs dut (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .STEP_X(STEP_X), .STEP_Y(STEP_Y), .LOAD(LOAD), .W_ACC(W_ACC),
        .MIP_LEVEL(MIP_LEVEL), .WRAP_LIMIT(WRAP_LIMIT), .U_COORD(U_COORD),
        .V_COORD(V_COORD), .PERSPECTIVE(PERSPECTIVE));

    // Free-running core clock.
    initial forever #2.5 MCLK = ~MCLK;

    // ------------------------------------------------------------------
    // Bus, stepper and compare tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Leaves the strobe up so a read may follow with no gap.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        RD <= 1'b0;
        ADDR <= a;
        WDATA <= d;
    endtask : wr

    // Read data exist only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge MCLK);
        RD <= 1'b1;
        WR <= 1'b0;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
    endtask : rd

    // One control pulse; outputs show the result one edge after it is taken.
    task automatic pulse(input logic l, input logic x, input logic y);
        @(posedge MCLK);
        WR <= 1'b0;
        LOAD <= l;
        STEP_X <= x;
        STEP_Y <= y;
        @(posedge MCLK);
        LOAD <= 1'b0;
        STEP_X <= 1'b0;
        STEP_Y <= 1'b0;
        @(posedge MCLK);
        #1;
    endtask : pulse

    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    // Each of the eleven parameter words read back straight after its write; bases keep twenty bits.
    task automatic t_regs();
        logic [31:0] v;
        for (int i = 0; i < 11; i++)
        begin
            v = 32'hF0E1_D2C3 ^ (32'h1357_9BDF * i);
            wr(OFFS[i], v);
            rd(OFFS[i], (i < 2) ? (v & 32'h000F_FFFF) : v);
        end
        wr(OFF_TEXEL_ROW_BASE, 32'hFFFF_FFFF);
        rd(OFF_TEXEL_ROW_BASE, 32'h000F_FFFF);
        wr(OFF_TEXEL_COLUMN_BASE, 32'hFFFF_FFFF);
        rd(OFF_TEXEL_COLUMN_BASE, 32'h000F_FFFF);
        wr(16'hB500, 32'hFFFF_FFFF);
        rd(16'hB500, 32'h0);
        for (int i = 0; i < 11; i++)
        begin
            wr(OFFS[i], VALS[i]);
        end
        wr(OFF_RENDER_CONTROL, 32'h0);
    endtask : t_regs

    // Load and steps accumulate the loaded operands; wrap limit only when enabled.
    task automatic t_steps();
        logic [31:0] d;
        // The load clears the coordinate starts, which keeps them non-negative.
        pulse(1'b1, 1'b0, 1'b0);
        chk(W_ACC, VALS[4]);
        chk(U_COORD, VALS[1]);
        chk(V_COORD, VALS[0]);
        chk({24'h0, MIP_LEVEL}, 32'h0);
        pulse(1'b0, 1'b1, 1'b1);
        chk(W_ACC, VALS[4] + VALS[2]);
        chk(U_COORD, VALS[1] + VALS[7]);
        chk(V_COORD, VALS[0] + VALS[6]);
        chk({24'h0, MIP_LEVEL}, {24'h0, VALS[5][26:19]});
        chk({28'h0, WRAP_LIMIT}, 32'h0);
        pulse(1'b0, 1'b0, 1'b1);
        chk(W_ACC, VALS[4] + VALS[2] + VALS[3]);
        chk(U_COORD, VALS[1] + VALS[7] + VALS[10]);
        chk(V_COORD, VALS[0] + VALS[6] + VALS[9]);
        d = VALS[5] + VALS[8];
        chk({24'h0, MIP_LEVEL}, {24'h0, d[26:19]});
        wr(OFF_RENDER_CONTROL, 32'h0400_0000);
        pulse(1'b0, 1'b1, 1'b0);
        d = d + VALS[5];
        chk({28'h0, WRAP_LIMIT}, {28'h0, d[30:27]});
        pulse(1'b1, 1'b1, 1'b1);
        chk(W_ACC, VALS[4]);
    endtask : t_steps

    // Every operation code: only the two perspective codes raise the flag.
    task automatic t_modes();
        logic [3:0] op;
        logic want;
        for (int i = 0; i < 16; i++)
        begin
            op = i[3:0];
            want = (op == OP_PERSPECTIVE_A) || (op == OP_PERSPECTIVE_B);
            wr(OFF_RENDER_CONTROL, {1'b0, op, 27'h0});
            pulse(1'b0, 1'b0, 1'b0);
            chk({31'h0, PERSPECTIVE}, {31'h0, want});
            chk({28'h0, WRAP_LIMIT}, 32'h0);
        end
    endtask : t_modes

    // ------------------------------------------------------------------
    // Main sequence and watchdog.
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge MCLK);
        RESET <= 1'b0;
        t_regs();
        t_steps();
        t_modes();
        tally_and_finish();
    end

    // The tests need well under a thousand cycles; this span means a hang.
    initial
    begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : test_ttsr_regs
